/* bench/testbench.sv */
// self-checking bench for the 8-bit timer with compare output
`default_nettype none
`include "tmr8_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] a_ctl = `TMR8_OFS_CONTROL;
    localparam logic [4:0] a_cnt = `TMR8_OFS_COUNT;
    localparam logic [4:0] a_cmp = `TMR8_OFS_COMPARE;
    localparam logic [4:0] a_msk = `TMR8_OFS_MASK;
    localparam logic [4:0] a_flg = `TMR8_OFS_FLAGS;
    // design inputs
    logic clk, rstn, rd_q, wr_q, gie, cvt, ovt, ext;
    logic [4:0] adr;
    logic [3:0] be;
    logic [31:0] wdat;
    // design outputs
    wire [31:0] rdat;
    wire wreq, cirq, oirq, pin, ovr;
    int error_cnt = 0;
    int n_tests = 0;
    int div[6] = '{1, 1, 8, 64, 256, 1024}; // divisor per clock select
    logic [31:0] seed = 32'h00000059;

    tmr8_top i_tmr8_top (.SYS_CLK(clk), .RESETN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd_q), .AVS_WRITE(wr_q),
        .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .GLOBAL_IRQ_ENABLE(gie), .COMPARE_VECTOR_TAKEN(cvt), .OVERFLOW_VECTOR_TAKEN(ovt),
        .COMPARE_IRQ(cirq), .OVERFLOW_IRQ(oirq), .EXTERNAL_COUNT_PIN(ext), .WAVEFORM_PIN(pin),
        .WAVEFORM_PIN_OVERRIDE(ovr));

    // 25 mhz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // control byte from its fields
    function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] com, input logic [2:0] cs,
            input logic f);
        return {f, m[0], com, m[1], cs};
    endfunction

    // non-pwm action of a forced match on the current level
    function automatic logic eforce(input logic [1:0] com, input logic p);
        case (com)
            2'h1: return !p;
            2'h2: return 1'b0;
            2'h3: return 1'b1;
            default: return p;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one avalon transfer: hold until wait is sampled low, then release and let an edge pass
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        adr <= a;
        wdat <= {24'h000000, d};
        wr_q <= w;
        rd_q <= !w;
        @(posedge clk iff !wreq);
        q = rdat[7:0];
        wr_q <= 1'b0;
        rd_q <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask

    // poll a flag bit, bounded so a dead timer cannot hang here
    task automatic waitf(input int b);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 400 && v[b] !== 1'b1; i++) begin
            rd(a_flg, v);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog: the tests need well under this span
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        test_done();
    end

    // main sequence
    initial begin
        logic [7:0] v, x, c, cmp;
        logic [1:0] m, com;
        logic p;
        int e;
        {rstn, rd_q, wr_q, gie, cvt, ovt, ext} = 7'h00;
        adr = 5'h00;
        be = 4'h1;
        wdat = 32'h00000000;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        // all registers and one unmapped word read zero
        for (int i = 0; i < 6; i++) begin
            rd(5'(i * 4), v);
            chk("reset value", v, 8'h00);
        end
        // mask bits hold; a write with lane 0 disabled is dropped
        x = 8'(rnd());
        wr(a_msk, x);
        be <= 4'h0;
        wr(a_msk, ~x);
        be <= 4'h1;
        rd(a_msk, v);
        chk("irq mask", v[1:0], x[1:0]);
        for (int i = 1; i < 3; i++) begin
            x = 8'(rnd());
            wr(5'(i * 4), x);
            rd(5'(i * 4), v);
            chk("count or compare", v, x);
        end
        // forced matches in every output mode; strobe uses the stored mode
        p = 1'b0;
        for (int i = 0; i < 8; i++) begin
            com = 2'(i >> 1);
            wr(a_ctl, ctl(2'h0, com, 3'h0, 1'b0));
            wr(a_ctl, ctl(2'h0, com, 3'h0, 1'b1));
            rd(a_ctl, v);
            chk("strobe reads zero", v, ctl(2'h0, com, 3'h0, 1'b0));
            p = eforce(com, p);
            chk("forced pin", pin, p);
            chk("pin owner", ovr, com != 2'h0);
        end
        rd(a_flg, v);
        chk("no flag from strobe", v, 8'h00);
        // each internal select runs a span of twenty of its periods; stop must count zero
        for (int i = 0; i < 6; i++) begin
            wr(a_cnt, 8'h00);
            wr(a_ctl, ctl(2'h0, 2'h0, 3'(i), 1'b0));
            repeat (20 * div[i] - 3) @(posedge clk);
            wr(a_ctl, 8'h00);
            rd(a_cnt, v);
            e = (i == 0) ? 0 : 20;
            chk("prescaled count", int'(v) >= e - 1 && int'(v) <= e + 1, 1'b1);
        end
        // pin edges: one more rise than fall, so the two selects differ
        for (int s = 6; s < 8; s++) begin
            wr(a_cnt, 8'h00);
            wr(a_ctl, ctl(2'h0, 2'h0, 3'(s), 1'b0));
            e = 3 + int'(rnd() % 5);
            repeat (e) begin
                ext <= 1'b1;
                repeat (3) @(posedge clk);
                ext <= 1'b0;
                repeat (3) @(posedge clk);
            end
            ext <= 1'b1;
            repeat (6) @(posedge clk);
            wr(a_ctl, 8'h00);
            ext <= 1'b0;
            rd(a_cnt, v);
            chk("pin edge count", v, 8'(e + s - 6));
        end
        // normal mode: one toggle, both flags, both requests
        wr(a_cmp, 8'hf8);
        wr(a_cnt, 8'hf0);
        wr(a_flg, 8'h03);
        wr(a_msk, 8'h03);
        gie <= 1'b1;
        wr(a_ctl, ctl(2'h0, 2'h1, 3'h1, 1'b0));
        waitf(0);
        wr(a_ctl, ctl(2'h0, 2'h1, 3'h0, 1'b0));
        rd(a_flg, v);
        chk("match and wrap flags", v, 8'h03);
        chk("toggled pin", pin, !p);
        chk("both requests", {cirq, oirq}, 2'b11);
        wr(a_msk, 8'h02);
        repeat (2) @(posedge clk);
        chk("overflow masked", {cirq, oirq}, 2'b10);
        gie <= 1'b0;
        repeat (2) @(posedge clk);
        chk("global gate", cirq, 1'b0);
        gie <= 1'b1;
        cvt <= 1'b1;
        @(posedge clk);
        cvt <= 1'b0;
        rd(a_flg, v);
        chk("vector clears match", v, 8'h01);
        ovt <= 1'b1;
        @(posedge clk);
        ovt <= 1'b0;
        rd(a_flg, v);
        chk("vector clears overflow", v, 8'h00);
        // a written count equal to compare cannot match on the next tick
        wr(a_cnt, 8'h40);
        wr(a_cmp, 8'h40);
        wr(a_ctl, ctl(2'h0, 2'h0, 3'h1, 1'b0));
        repeat (100) @(posedge clk);
        wr(a_ctl, 8'h00);
        rd(a_flg, v);
        chk("blocked match", v, 8'h00);
        // clear on match keeps the count inside its period
        cmp = 8'h10 + 8'(rnd() % 48);
        wr(a_cmp, cmp);
        wr(a_cnt, 8'h00);
        wr(a_ctl, ctl(2'h2, 2'h0, 3'h1, 1'b0));
        waitf(1);
        repeat (int'(rnd() % 64)) @(posedge clk);
        wr(a_ctl, 8'h00);
        rd(a_cnt, c);
        chk("count in period", c <= cmp, 1'b1);
        rd(a_flg, v);
        chk("no wrap in period", v, 8'h02);
        wr(a_flg, 8'h02);
        rd(a_flg, v);
        chk("write one clears", v, 8'h00);
        // pwm levels against the frozen count; every third compare sits at top
        for (int i = 0; i < 12; i++) begin
            m = i[0] ? 2'h3 : 2'h1;
            com = i[1] ? 2'h3 : 2'h2;
            cmp = (i % 3 == 0) ? 8'hff : (8'(rnd()) | 8'h01);
            wr(a_cmp, cmp);
            wr(a_cnt, 8'h00);
            wr(a_ctl, ctl(m, com, 3'h1, 1'b0));
            // first overflow may be stale, so wait a full period
            waitf(0);
            wr(a_flg, 8'h03);
            waitf(0);
            rd(a_cnt, c);
            chk("overflow near bottom", c < 8'h20, 1'b1);
            repeat (int'(rnd() % 300)) @(posedge clk);
            wr(a_ctl, ctl(m, com, 3'h0, 1'b0));
            rd(a_cnt, c);
            // a phase count sitting on compare is reached from either side
            if (m == 2'h3 || c != cmp) begin
                chk("pwm level", pin, (c <= cmp) ^ com[0]);
            end
        end
        // second reset in mid-run
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(a_ctl, v);
        chk("control after reset", v, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire

/* bench/tmr8_monitor.sv */
// port-level assertions for the 8-bit timer with compare output
`default_nettype none
module tmr8_monitor (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // register bus
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // interrupt side
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic COMPARE_VECTOR_TAKEN,
    input wire logic OVERFLOW_VECTOR_TAKEN,
    input wire logic COMPARE_IRQ,
    input wire logic OVERFLOW_IRQ,
    // pin ownership
    input wire logic WAVEFORM_PIN_OVERRIDE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // the only causes that may take a request away (global gate, vector, or any bus write)
    wire logic cmp_drop = !GLOBAL_IRQ_ENABLE || COMPARE_VECTOR_TAKEN || AVS_WRITE;
    wire logic ovf_drop = !GLOBAL_IRQ_ENABLE || OVERFLOW_VECTOR_TAKEN || AVS_WRITE;

    chk_wait_first:
        assert property (($rose(AVS_READ) || $rose(AVS_WRITE)) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("request not answered after one wait cycle");
    chk_wait_bound:
        assert property ((AVS_READ || AVS_WRITE) |-> ##[0:1] !AVS_WAITREQUEST)
        else $error("request held in wait too long");
    chk_wait_idle:
        assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
        else $error("wait raised with no request");
    chk_data_lane:
        assert property (AVS_READDATA[31:8] == 24'h000000)
        else $error("read data outside lane zero");
    chk_cmp_gate:
        assert property (COMPARE_IRQ |-> $past(GLOBAL_IRQ_ENABLE))
        else $error("compare request without global enable");
    chk_ovf_gate:
        assert property (OVERFLOW_IRQ |-> $past(GLOBAL_IRQ_ENABLE))
        else $error("overflow request without global enable");
    chk_cmp_drop:
        assert property ($fell(COMPARE_IRQ) |-> $past(cmp_drop) || $past(cmp_drop, 2) || $past(cmp_drop, 3))
        else $error("compare request dropped without cause");
    chk_ovf_drop:
        assert property ($fell(OVERFLOW_IRQ) |-> $past(ovf_drop) || $past(ovf_drop, 2) || $past(ovf_drop, 3))
        else $error("overflow request dropped without cause");
    chk_pin_owner:
        assert property ($changed(WAVEFORM_PIN_OVERRIDE) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
        else $error("pin ownership changed without a write");
endmodule

bind tmr8_top tmr8_monitor i_tmr8_monitor (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .COMPARE_VECTOR_TAKEN(COMPARE_VECTOR_TAKEN),
    .OVERFLOW_VECTOR_TAKEN(OVERFLOW_VECTOR_TAKEN), .COMPARE_IRQ(COMPARE_IRQ),
    .OVERFLOW_IRQ(OVERFLOW_IRQ), .WAVEFORM_PIN_OVERRIDE(WAVEFORM_PIN_OVERRIDE));
`default_nettype wire

/* rtl/tmr8_clksel.v */
// clock select: free-running prescaler, external pin sync and edge detect
`default_nettype none
`include "tmr8_defs.vh"

module tmr8_clksel (
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // selection and external pin
    input wire [2:0] clock_select,
    input wire external_count_pin,
    // one-cycle timer clock enable
    output reg timer_tick
);

    reg [9:0] presc_q; // free-running divider, never gated by the select
    reg pin_s1_q; // first synchroniser stage, read only by the second
    reg pin_s2_q; // synchronised pin level
    reg pin_old_q; // previous synchronised level for edge detect
    wire pin_rise;
    wire pin_fall;

    // free-running prescaler, so the first prescaled count may come 1..N cycles late
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            presc_q <= 10'h000;
        end else begin
            presc_q <= presc_q + 10'h001;
        end
    end

    // pin is sampled even when driven as an output so software can count by toggling it
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_old_q <= 1'b0;
        end else begin
            pin_s1_q <= external_count_pin;
            pin_s2_q <= pin_s1_q;
            pin_old_q <= pin_s2_q;
        end
    end

    assign pin_rise = pin_s2_q & ~pin_old_q;
    assign pin_fall = ~pin_s2_q & pin_old_q;

    // pick the enable source for the selected code
    always @* begin
        case (clock_select)
            `TMR8_CS_STOP: timer_tick = 1'b0;
            `TMR8_CS_DIV1: timer_tick = 1'b1;
            `TMR8_CS_DIV8: timer_tick = &(presc_q | ~`TMR8_TAP8);
            `TMR8_CS_DIV64: timer_tick = &(presc_q | ~`TMR8_TAP64);
            `TMR8_CS_DIV256: timer_tick = &(presc_q | ~`TMR8_TAP256);
            `TMR8_CS_DIV1024: timer_tick = &(presc_q | ~`TMR8_TAP1024);
            `TMR8_CS_EXT_FALL: timer_tick = pin_fall;
            `TMR8_CS_EXT_RISE: timer_tick = pin_rise;
            default: timer_tick = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

/* rtl/tmr8_defs.vh */
// constants for the 8-bit timer/counter with compare output
`ifndef TMR8_DEFS_VH
`define TMR8_DEFS_VH

// register byte offsets on the avalon slave
`define TMR8_OFS_CONTROL 5'h00
`define TMR8_OFS_COUNT 5'h04
`define TMR8_OFS_COMPARE 5'h08
`define TMR8_OFS_MASK 5'h0c
`define TMR8_OFS_FLAGS 5'h10

// control register field positions
`define TMR8_CTL_FORCE 7
`define TMR8_CTL_MODE_LO 6
`define TMR8_CTL_COM_HI 5
`define TMR8_CTL_COM_LO 4
`define TMR8_CTL_MODE_HI 3
`define TMR8_CTL_SEL_HI 2

// mask and flag bit positions
`define TMR8_BIT_COMPARE 1
`define TMR8_BIT_OVERFLOW 0

// reset values
`define TMR8_RST_CONTROL 8'h00
`define TMR8_RST_COUNT 8'h00
`define TMR8_RST_COMPARE 8'h00
`define TMR8_RST_MASK 8'h00
`define TMR8_RST_FLAGS 8'h00

// waveform modes
`define TMR8_MODE_NORMAL 2'h0
`define TMR8_MODE_PHASE 2'h1
`define TMR8_MODE_CTC 2'h2
`define TMR8_MODE_FAST 2'h3

// count limits
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00

// clock select codes
`define TMR8_CS_STOP 3'h0
`define TMR8_CS_DIV1 3'h1
`define TMR8_CS_DIV8 3'h2
`define TMR8_CS_DIV64 3'h3
`define TMR8_CS_DIV256 3'h4
`define TMR8_CS_DIV1024 3'h5
`define TMR8_CS_EXT_FALL 3'h6
`define TMR8_CS_EXT_RISE 3'h7

// prescaler tap masks: a tap fires when these low bits are all ones
`define TMR8_TAP8 10'h007
`define TMR8_TAP64 10'h03f
`define TMR8_TAP256 10'h0ff
`define TMR8_TAP1024 10'h3ff

`endif

/* rtl/tmr8_top.v */
// 8-bit timer/counter with one compare output, flags and avalon register slave
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`default_nettype none
`include "tmr8_defs.vh"

// Operation
// - nonzero output mode hands pin to waveform
// - non-PWM: disconnect, toggle, clear, set on match
// - fast PWM: 10 clear-match/set-bottom, 11 inverse
// - fast PWM compare at top: skip match
// - phase PWM: 10 clear up, set down
// - phase PWM compare at top: act at top
// - clock select stop, direct, prescaler taps
// - select 110 falling, 111 rising pin
// - count pin counts even as output
// - count read/write; write blocks next match
// - compare value checked against count always
// - match flag: set, vector or one clears
// - compare irq needs global, enable, flag
// - overflow flag: set, vector or one clears
// - overflow irq needs global, enable, flag
// - phase PWM overflow at bottom reversal
// - enables at mask bits 1, 0, reset zero
// - waveform mode selects normal/phase/ctc/fast
// - force strobe acts immediately in non-PWM modes, reads zero
module tmr8_top (
    // clock and reset
    input wire SYS_CLK,
    input wire RESETN,
    // avalon-mm slave
    input wire [4:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [3:0] AVS_BYTEENABLE,
    input wire [31:0] AVS_WRITEDATA,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    // cpu interrupt side
    input wire GLOBAL_IRQ_ENABLE,
    input wire COMPARE_VECTOR_TAKEN,
    input wire OVERFLOW_VECTOR_TAKEN,
    output reg COMPARE_IRQ,
    output reg OVERFLOW_IRQ,
    // pins
    input wire EXTERNAL_COUNT_PIN,
    output reg WAVEFORM_PIN,
    output reg WAVEFORM_PIN_OVERRIDE
);

    // one-hot bus handshake states
    localparam [1:0] ST_IDLE = 2'b01; // waiting for a request
    localparam [1:0] ST_ACK = 2'b10; // answering, waitrequest low

    // software visible state
    reg [7:0] control_q; // timer_control_register without the force strobe
    reg [7:0] count_q; // timer_count
    reg [7:0] compare_q; // compare_value
    reg [7:0] mask_q; // timer_irq_mask
    reg [7:0] flags_q; // timer_irq_flags
    // internal timer state
    reg down_q; // phase correct direction, high while counting down
    reg block_q; // match blocked for the next timer clock after a count write
    reg wave_q; // waveform output register
    reg [1:0] bus_q; // bus handshake state

    // decoded fields
    wire [1:0] waveform_mode;
    wire [1:0] compare_output_mode;
    wire [2:0] clock_select;
    wire timer_tick;

    // bus strobes
    wire req;
    wire wr_go;
    wire lane0;
    wire wr_control;
    wire wr_count;
    wire wr_compare;
    wire wr_mask;
    wire wr_flags;
    wire force_go;

    // timer events
    wire cnt_eq;
    wire cnt_top;
    wire match;
    reg [7:0] count_d;
    reg down_d;
    reg ovf_evt;
    reg [1:0] act;
    reg wave_d;
    reg [31:0] rdata_d;

    // output action code: 00 hold, 01 toggle, 10 clear, 11 set
    function wave_act;
        input [1:0] code;
        input cur;
        begin
            case (code)
                2'b01: wave_act = ~cur;
                2'b10: wave_act = 1'b0;
                2'b11: wave_act = 1'b1;
                default: wave_act = cur;
            endcase
        end
    endfunction

    // mode is split across bits 3 and 6, kept for layout compatibility
    assign waveform_mode = {control_q[`TMR8_CTL_MODE_HI], control_q[`TMR8_CTL_MODE_LO]};
    assign compare_output_mode = control_q[`TMR8_CTL_COM_HI:`TMR8_CTL_COM_LO];
    assign clock_select = control_q[`TMR8_CTL_SEL_HI:0];

    // prescaler, pin synchroniser and clock select
    tmr8_clksel u_clksel (
        .sys_clk(SYS_CLK),
        .resetn(RESETN),
        .clock_select(clock_select),
        .external_count_pin(EXTERNAL_COUNT_PIN),
        .timer_tick(timer_tick)
    );

    // -------- avalon slave --------

    // every access waits exactly one cycle, so readdata is always from a flop
    assign req = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~bus_q[1];
    assign wr_go = AVS_WRITE & bus_q[1];
    // registers live in byte lane 0; other lanes are dropped
    assign lane0 = AVS_BYTEENABLE[0];
    assign wr_control = wr_go & lane0 & (AVS_ADDRESS == `TMR8_OFS_CONTROL);
    assign wr_count = wr_go & lane0 & (AVS_ADDRESS == `TMR8_OFS_COUNT);
    assign wr_compare = wr_go & lane0 & (AVS_ADDRESS == `TMR8_OFS_COMPARE);
    assign wr_mask = wr_go & lane0 & (AVS_ADDRESS == `TMR8_OFS_MASK);
    assign wr_flags = wr_go & lane0 & (AVS_ADDRESS == `TMR8_OFS_FLAGS);

    // handshake state: idle, then one answering cycle
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bus_q <= ST_IDLE;
        end else begin
            case (bus_q)
                ST_IDLE: begin
                    if (req) begin
                        bus_q <= ST_ACK;
                    end
                end
                ST_ACK: bus_q <= ST_IDLE;
                default: bus_q <= ST_IDLE;
            endcase
        end
    end

    // read mux; unmapped addresses read zero, force strobe reads zero
    always @* begin
        rdata_d = 32'h00000000;
        case (AVS_ADDRESS)
            `TMR8_OFS_CONTROL: rdata_d[7:0] = control_q;
            `TMR8_OFS_COUNT: rdata_d[7:0] = count_q;
            `TMR8_OFS_COMPARE: rdata_d[7:0] = compare_q;
            `TMR8_OFS_MASK: rdata_d[7:0] = mask_q;
            `TMR8_OFS_FLAGS: rdata_d[7:0] = flags_q;
            default: rdata_d = 32'h00000000;
        endcase
    end

    // read data is captured on the edge that enters the answering cycle
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            AVS_READDATA <= 32'h00000000;
        end else if (AVS_READ && bus_q[0]) begin
            AVS_READDATA <= rdata_d;
        end
    end

    // -------- control, compare and mask registers --------

    // the force bit is never stored so it always reads as zero
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            control_q <= `TMR8_RST_CONTROL;
            compare_q <= `TMR8_RST_COMPARE;
            mask_q <= `TMR8_RST_MASK;
        end else begin
            if (wr_control) begin
                control_q <= {1'b0, AVS_WRITEDATA[`TMR8_CTL_FORCE-1:0]};
            end
            if (wr_compare) begin
                compare_q <= AVS_WRITEDATA[7:0];
            end
            if (wr_mask) begin
                mask_q <= AVS_WRITEDATA[7:0];
            end
        end
    end

    // force only has effect in the two non-PWM modes, using the stored output mode
    assign force_go = wr_control & AVS_WRITEDATA[`TMR8_CTL_FORCE] &
                      ~control_q[`TMR8_CTL_MODE_LO];

    // -------- counter --------

    // comparator runs every cycle; it only counts as a match on a timer clock
    assign cnt_eq = (count_q == compare_q);
    assign cnt_top = (count_q == `TMR8_MAX);
    assign match = timer_tick & cnt_eq & ~block_q;

    // next count and direction for each waveform mode
    always @* begin
        count_d = count_q;
        down_d = down_q;
        ovf_evt = 1'b0;
        if (timer_tick) begin
            case (waveform_mode)
                `TMR8_MODE_PHASE: begin
                    // dual slope, reverses at max and at bottom
                    if (!down_q && cnt_top) begin
                        down_d = 1'b1;
                        count_d = count_q - 8'h01;
                    end else if (down_q && count_q == `TMR8_BOTTOM) begin
                        down_d = 1'b0;
                        count_d = count_q + 8'h01;
                        ovf_evt = 1'b1;
                    end else if (down_q) begin
                        count_d = count_q - 8'h01;
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                end
                `TMR8_MODE_CTC: begin
                    // clear happens on the same timer clock as the match
                    if (cnt_eq) begin
                        count_d = `TMR8_BOTTOM;
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                    ovf_evt = cnt_top & ~cnt_eq;
                    down_d = 1'b0;
                end
                default: begin
                    // normal and fast PWM: single slope with wrap
                    count_d = count_q + 8'h01;
                    ovf_evt = cnt_top;
                    down_d = 1'b0;
                end
            endcase
        end
        if (waveform_mode != `TMR8_MODE_PHASE) begin
            down_d = 1'b0;
        end
    end

    // software write to the count wins over the timer clock
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            count_q <= `TMR8_RST_COUNT;
            down_q <= 1'b0;
            block_q <= 1'b0;
        end else begin
            down_q <= down_d;
            if (wr_count) begin
                count_q <= AVS_WRITEDATA[7:0];
                block_q <= 1'b1;
            end else begin
                count_q <= count_d;
                if (timer_tick) begin
                    block_q <= 1'b0;
                end
            end
        end
    end

    // -------- waveform generator --------

    // pick the action for this cycle from mode, output mode and events
    always @* begin
        act = 2'b00;
        case (waveform_mode)
            `TMR8_MODE_FAST: begin
                // 01 reserved: no action
                if (compare_output_mode[1]) begin
                    if (timer_tick && cnt_top) begin
                        // bottom: 10 sets, 11 clears
                        act = {1'b1, ~compare_output_mode[0]};
                    end else if (match && compare_q != `TMR8_MAX) begin
                        // compare at top: match skipped, bottom still acts
                        act = compare_output_mode;
                    end
                end
            end
            `TMR8_MODE_PHASE: begin
                if (compare_output_mode[1]) begin
                    if (compare_q == `TMR8_MAX) begin
                        // compare at top: match skipped, act as down match at top
                        if (timer_tick && cnt_top && !down_q) begin
                            act = {1'b1, ~compare_output_mode[0]};
                        end
                    end else if (match) begin
                        // up: 10 clears, 11 sets; down: inverse
                        act = {1'b1, compare_output_mode[0] ^ down_q};
                    end
                end
            end
            default: begin
                // normal and ctc: toggle, clear or set on match or force
                if (match || force_go) begin
                    act = compare_output_mode;
                end
            end
        endcase
        wave_d = wave_act(act, wave_q);
    end

    // waveform register and pin ownership
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wave_q <= 1'b0;
            WAVEFORM_PIN <= 1'b0;
            WAVEFORM_PIN_OVERRIDE <= 1'b0;
        end else begin
            wave_q <= wave_d;
            WAVEFORM_PIN <= wave_d;
            // pin driver still needs the port direction bit outside this block
            WAVEFORM_PIN_OVERRIDE <= |compare_output_mode;
        end
    end

    // -------- flags and interrupts --------

    // hardware set wins over a software or vector clear in the same cycle
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            flags_q <= `TMR8_RST_FLAGS;
        end else begin
            if (match) begin
                flags_q[`TMR8_BIT_COMPARE] <= 1'b1;
            end else if (COMPARE_VECTOR_TAKEN ||
                         (wr_flags && AVS_WRITEDATA[`TMR8_BIT_COMPARE])) begin
                flags_q[`TMR8_BIT_COMPARE] <= 1'b0;
            end
            if (ovf_evt) begin
                flags_q[`TMR8_BIT_OVERFLOW] <= 1'b1;
            end else if (OVERFLOW_VECTOR_TAKEN ||
                         (wr_flags && AVS_WRITEDATA[`TMR8_BIT_OVERFLOW])) begin
                flags_q[`TMR8_BIT_OVERFLOW] <= 1'b0;
            end
        end
    end

    // requests are registered so they follow the flags by one cycle
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            COMPARE_IRQ <= 1'b0;
            OVERFLOW_IRQ <= 1'b0;
        end else begin
            COMPARE_IRQ <= GLOBAL_IRQ_ENABLE & mask_q[`TMR8_BIT_COMPARE] &
                           flags_q[`TMR8_BIT_COMPARE];
            OVERFLOW_IRQ <= GLOBAL_IRQ_ENABLE & mask_q[`TMR8_BIT_OVERFLOW] &
                            flags_q[`TMR8_BIT_OVERFLOW];
        end
    end

endmodule
`default_nettype wire
